// ---- verilog/tc_chan_pkg.sv ----
package tc_chan_pkg;

  // Register byte offsets
  localparam logic [5:0] OFF_COUNT = 6'h00;
  localparam logic [5:0] OFF_MATCH_A = 6'h04;
  localparam logic [5:0] OFF_MATCH_B = 6'h08;
  localparam logic [5:0] OFF_PERIOD = 6'h0c;
  localparam logic [5:0] OFF_STATUS = 6'h10;
  localparam logic [5:0] OFF_IRQ_EN = 6'h14;
  localparam logic [5:0] OFF_IRQ_DIS = 6'h18;
  localparam logic [5:0] OFF_IRQ_MASK = 6'h1c;
  localparam logic [5:0] OFF_CTRL = 6'h20;
  localparam logic [5:0] OFF_MODE = 6'h24;

  // Command bits of the control port
  localparam int CTRL_CLK_EN = 0;
  localparam int CTRL_CLK_DIS = 1;
  localparam int CTRL_SW_TRIG = 2;

  // Mode register fields, each effect or edge field two bits wide
  localparam int MODE_WAVE = 15;
  localparam int EXT_EDGE_LSB = 8;
  localparam int LOAD_A_EDGE_LSB = 16;
  localparam int LOAD_B_EDGE_LSB = 18;
  localparam int MATCH_A_EFF_A_LSB = 16;
  localparam int PERIOD_EFF_A_LSB = 18;
  localparam int EXT_EFF_A_LSB = 20;
  localparam int SW_EFF_A_LSB = 22;
  localparam int MATCH_B_EFF_B_LSB = 24;
  localparam int PERIOD_EFF_B_LSB = 26;
  localparam int EXT_EFF_B_LSB = 28;
  localparam int SW_EFF_B_LSB = 30;

  // Status bit positions; the interrupt ports share the low byte
  localparam int FLAG_OVERFLOW = 0;
  localparam int FLAG_OVERRUN = 1;
  localparam int FLAG_MATCH_A = 2;
  localparam int FLAG_MATCH_B = 3;
  localparam int FLAG_PERIOD = 4;
  localparam int FLAG_LOAD_A = 5;
  localparam int FLAG_LOAD_B = 6;
  localparam int FLAG_EXT_TRIG = 7;
  localparam int STAT_CLOCK_ON = 16;
  localparam int STAT_MIRROR_A = 17;
  localparam int STAT_MIRROR_B = 18;
  localparam int NUM_FLAGS = 8;

  // Flags that exist only in one mode
  localparam logic [7:0] CAPTURE_ONLY_FLAGS = 8'h62;
  localparam logic [7:0] WAVE_ONLY_FLAGS = 8'h0c;

  localparam logic [31:0] MODE_RESET = 32'h0000_0000;

  typedef enum logic [1:0] {
    EFF_NONE = 2'h0,
    EFF_SET = 2'h1,
    EFF_CLEAR = 2'h2,
    EFF_TOGGLE = 2'h3
  } effect_e;

  typedef enum logic [1:0] {
    EDGE_NONE = 2'h0,
    EDGE_RISE = 2'h1,
    EDGE_FALL = 2'h2,
    EDGE_BOTH = 2'h3
  } edge_e;

  typedef struct packed {
    logic [5:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } bus_req_s;

  typedef struct packed {
    logic line_a_in;
    logic line_b_in;
    logic ext_event_in;
  } pins_in_s;

endpackage : tc_chan_pkg

// ---- verilog/timer_channel_regs_status.sv ----
// Function
// - Software trigger in wave mode applies its two-bit effect to line A.
// - B match in wave mode applies its two-bit effect to line B.
// - Period match in wave mode applies its two-bit effect to line B.
// - External event in wave mode applies its two-bit effect to line B.
// - Software trigger in wave mode applies its two-bit effect to line B.
// - Live 16-bit count readable in low bits, upper bits zero.
// - A match value: read-only in capture mode, writable in wave mode.
// - B match value: read-only in capture mode, writable in wave mode.
// - Period value readable and writable in both modes.
// - Overflow sets status bit 0, held until a status read clears it.
// - Capture mode: double load without read sets bit 1; zero in wave.
// - Wave mode: A and B compares set bits 2 and 3; zero in capture.
// - Period match sets bit 4 in either mode, cleared by status read.
// - Capture mode: A and B loads set bits 5 and 6; zero in wave.
// - External trigger sets bit 7, held until next status read.
// - Status bit 16 shows whether the counter clock runs.
// - Bits 17 and 18 mirror lines A and B, pin or driven level.
// - Writing ones to the enable port enables those interrupts.
// - Writing ones to the disable port disables those interrupts.
// - Mode bit: 0 capture, 1 wave with line effects.
// - Read-only mask shows which event interrupts are enabled.
//
// The placing of the registers and the plain strobed port were chosen for this implementation.
module timer_channel_regs_status #(
  parameter int CNT_W = 16
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rstn,
  // Register port
  input wire tc_chan_pkg::bus_req_s bus_req,
  output logic [31:0] rdata,
  // Timer lines and external event
  input wire tc_chan_pkg::pins_in_s pins_in,
  output logic line_a_out,
  output logic line_a_oe_n,
  output logic line_b_out,
  output logic line_b_oe_n,
  // Channel interrupt
  output logic irq
);
  import tc_chan_pkg::*;

  if (CNT_W < 2 || CNT_W > 16)
  begin : g_width_check
    $error("CNT_W must lie between 2 and 16");
  end

  typedef struct packed {
    logic [CNT_W-1:0] count;
    logic [CNT_W-1:0] match_a;
    logic [CNT_W-1:0] match_b;
    logic [CNT_W-1:0] period;
    logic [31:0] mode;
    logic [7:0] flags;
    logic [7:0] mask;
    logic clock_on;
    logic a_unread;
    logic b_unread;
    logic [2:0] sync_a;
    logic [2:0] sync_b;
    logic [2:0] sync_e;
    logic lvl_a;
    logic lvl_b;
    logic lvl_e;
    logic line_a_o;
    logic line_b_o;
    logic oe_n;
    logic irq;
    logic [31:0] rdata;
  } state_s;

  state_s st_reg;
  state_s st_next;

  function automatic logic apply_effect(input logic cur, input logic [1:0] eff);
    case (effect_e'(eff))
      EFF_SET: apply_effect = 1'b1;
      EFF_CLEAR: apply_effect = 1'b0;
      EFF_TOGGLE: apply_effect = ~cur;
      default: apply_effect = cur;
    endcase
  endfunction : apply_effect

  function automatic logic edge_hit(input logic [1:0] sel, input logic rise, input logic fall);
    case (edge_e'(sel))
      EDGE_RISE: edge_hit = rise;
      EDGE_FALL: edge_hit = fall;
      EDGE_BOTH: edge_hit = rise | fall;
      default: edge_hit = 1'b0;
    endcase
  endfunction : edge_hit

  // Three-stage sampling; a level counts once the last two agree
  function automatic logic filter_level(input logic [2:0] sync, input logic lvl);
    filter_level = (sync[1] == sync[2]) ? sync[2] : lvl;
  endfunction : filter_level

  logic wave;
  logic wr_ctrl;
  logic sw_trig;
  logic clk_en_cmd;
  logic clk_dis_cmd;
  logic rise_a;
  logic fall_a;
  logic rise_e;
  logic fall_e;
  logic ext_hit;
  logic trigger;
  logic overflow;
  logic cmp_a;
  logic cmp_b;
  logic cmp_c;
  logic load_a;
  logic load_b;
  logic rd_status;
  logic [7:0] set_vec;
  logic [7:0] shown_flags;
  logic [31:0] rd_mux;

  always_comb
  begin
    st_next = st_reg;
    wave = st_reg.mode[MODE_WAVE];

    // Pin sampling
    st_next.sync_a = {st_reg.sync_a[1:0], pins_in.line_a_in};
    st_next.sync_b = {st_reg.sync_b[1:0], pins_in.line_b_in};
    st_next.sync_e = {st_reg.sync_e[1:0], pins_in.ext_event_in};
    st_next.lvl_a = filter_level(st_reg.sync_a, st_reg.lvl_a);
    st_next.lvl_b = filter_level(st_reg.sync_b, st_reg.lvl_b);
    st_next.lvl_e = filter_level(st_reg.sync_e, st_reg.lvl_e);
    rise_a = st_next.lvl_a & ~st_reg.lvl_a;
    fall_a = ~st_next.lvl_a & st_reg.lvl_a;
    rise_e = st_next.lvl_e & ~st_reg.lvl_e;
    fall_e = ~st_next.lvl_e & st_reg.lvl_e;

    // Commands
    wr_ctrl = bus_req.wr && (bus_req.addr == OFF_CTRL);
    clk_en_cmd = wr_ctrl & bus_req.wdata[CTRL_CLK_EN];
    clk_dis_cmd = wr_ctrl & bus_req.wdata[CTRL_CLK_DIS];
    sw_trig = wr_ctrl & bus_req.wdata[CTRL_SW_TRIG];
    ext_hit = edge_hit(st_reg.mode[EXT_EDGE_LSB +: 2], rise_e, fall_e);
    trigger = sw_trig | ext_hit;

    // Disable beats enable and trigger in the same write
    if (clk_dis_cmd)
      st_next.clock_on = 1'b0;
    else if (clk_en_cmd || trigger)
      st_next.clock_on = 1'b1;

    // Counter and compares
    overflow = st_reg.clock_on && !trigger && (st_reg.count == {CNT_W{1'b1}});
    cmp_a = st_reg.clock_on && (st_reg.count == st_reg.match_a);
    cmp_b = st_reg.clock_on && (st_reg.count == st_reg.match_b);
    cmp_c = st_reg.clock_on && (st_reg.count == st_reg.period);
    if (trigger)
      st_next.count = '0;
    else if (st_reg.clock_on)
      st_next.count = st_reg.count + CNT_W'(1);

    // Captures happen on line A edges only in capture mode
    load_a = !wave && edge_hit(st_reg.mode[LOAD_A_EDGE_LSB +: 2], rise_a, fall_a);
    load_b = !wave && edge_hit(st_reg.mode[LOAD_B_EDGE_LSB +: 2], rise_a, fall_a);

    // Register writes
    if (bus_req.wr)
    begin
      case (bus_req.addr)
        OFF_MATCH_A:
          if (wave)
            st_next.match_a = bus_req.wdata[CNT_W-1:0];
        OFF_MATCH_B:
          if (wave)
            st_next.match_b = bus_req.wdata[CNT_W-1:0];
        OFF_PERIOD: st_next.period = bus_req.wdata[CNT_W-1:0];
        OFF_MODE: st_next.mode = bus_req.wdata;
        OFF_IRQ_EN: st_next.mask = st_reg.mask | bus_req.wdata[NUM_FLAGS-1:0];
        OFF_IRQ_DIS: st_next.mask = st_reg.mask & ~bus_req.wdata[NUM_FLAGS-1:0];
        default: ;
      endcase
    end

    // Reading a value marks it seen; a load in the same cycle wins
    if (bus_req.rd && bus_req.addr == OFF_MATCH_A)
      st_next.a_unread = 1'b0;
    if (bus_req.rd && bus_req.addr == OFF_MATCH_B)
      st_next.b_unread = 1'b0;
    if (load_a)
    begin
      st_next.match_a = st_reg.count;
      st_next.a_unread = 1'b1;
    end
    if (load_b)
    begin
      st_next.match_b = st_reg.count;
      st_next.b_unread = 1'b1;
    end

    // Sticky flags
    set_vec = '0;
    set_vec[FLAG_OVERFLOW] = overflow;
    set_vec[FLAG_OVERRUN] = (load_a && st_reg.a_unread) || (load_b && st_reg.b_unread);
    set_vec[FLAG_MATCH_A] = wave && cmp_a;
    set_vec[FLAG_MATCH_B] = wave && cmp_b;
    set_vec[FLAG_PERIOD] = cmp_c;
    set_vec[FLAG_LOAD_A] = load_a;
    set_vec[FLAG_LOAD_B] = load_b;
    set_vec[FLAG_EXT_TRIG] = ext_hit;
    rd_status = bus_req.rd && (bus_req.addr == OFF_STATUS);
    // Set wins over the read-clear so no event is lost
    st_next.flags = (rd_status ? 8'h00 : st_reg.flags) | set_vec;

    // Line effects, later assignments take priority
    st_next.line_a_o = st_reg.line_a_o;
    st_next.line_b_o = st_reg.line_b_o;
    if (wave)
    begin
      if (cmp_a)
        st_next.line_a_o = apply_effect(st_next.line_a_o, st_reg.mode[MATCH_A_EFF_A_LSB +: 2]);
      if (cmp_c)
        st_next.line_a_o = apply_effect(st_next.line_a_o, st_reg.mode[PERIOD_EFF_A_LSB +: 2]);
      if (ext_hit)
        st_next.line_a_o = apply_effect(st_next.line_a_o, st_reg.mode[EXT_EFF_A_LSB +: 2]);
      if (sw_trig)
        st_next.line_a_o = apply_effect(st_next.line_a_o, st_reg.mode[SW_EFF_A_LSB +: 2]);
      if (cmp_b)
        st_next.line_b_o = apply_effect(st_next.line_b_o, st_reg.mode[MATCH_B_EFF_B_LSB +: 2]);
      if (cmp_c)
        st_next.line_b_o = apply_effect(st_next.line_b_o, st_reg.mode[PERIOD_EFF_B_LSB +: 2]);
      if (ext_hit)
        st_next.line_b_o = apply_effect(st_next.line_b_o, st_reg.mode[EXT_EFF_B_LSB +: 2]);
      if (sw_trig)
        st_next.line_b_o = apply_effect(st_next.line_b_o, st_reg.mode[SW_EFF_B_LSB +: 2]);
    end
    st_next.oe_n = ~st_next.mode[MODE_WAVE];

    // Read data; flags of the other mode read as zero
    shown_flags = st_reg.flags & ~(wave ? CAPTURE_ONLY_FLAGS : WAVE_ONLY_FLAGS);
    rd_mux = '0;
    case (bus_req.addr)
      OFF_COUNT: rd_mux = 32'(st_reg.count);
      OFF_MATCH_A: rd_mux = 32'(st_reg.match_a);
      OFF_MATCH_B: rd_mux = 32'(st_reg.match_b);
      OFF_PERIOD: rd_mux = 32'(st_reg.period);
      OFF_STATUS:
      begin
        rd_mux[NUM_FLAGS-1:0] = shown_flags;
        rd_mux[STAT_CLOCK_ON] = st_reg.clock_on;
        rd_mux[STAT_MIRROR_A] = wave ? st_reg.line_a_o : st_reg.lvl_a;
        rd_mux[STAT_MIRROR_B] = wave ? st_reg.line_b_o : st_reg.lvl_b;
      end
      OFF_IRQ_MASK: rd_mux[NUM_FLAGS-1:0] = st_reg.mask;
      OFF_MODE: rd_mux = st_reg.mode;
      default: rd_mux = '0;
    endcase
    st_next.rdata = bus_req.rd ? rd_mux : 32'h0000_0000;

    // Interrupt follows the flag and mask registers exactly
    st_next.irq = |(st_next.flags & st_next.mask);
  end

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      st_reg <= '0;
      st_reg.mode <= MODE_RESET;
      st_reg.oe_n <= 1'b1;
    end
    else
      st_reg <= st_next;
  end

  assign rdata = st_reg.rdata;
  assign line_a_out = st_reg.line_a_o;
  assign line_b_out = st_reg.line_b_o;
  assign line_a_oe_n = st_reg.oe_n;
  assign line_b_oe_n = st_reg.oe_n;
  assign irq = st_reg.irq;

  a_overflow_flag: assert property (@(posedge clk) disable iff (!rstn)
    overflow |=> st_reg.flags[FLAG_OVERFLOW] && st_reg.count == '0)
    else $error("overflow did not set its flag");

  a_status_clear: assert property (@(posedge clk) disable iff (!rstn)
    (rd_status && set_vec == 8'h00) |=> st_reg.flags == 8'h00 ##1 (st_reg.flags == 8'h00 || $past(set_vec) != 8'h00))
    else $error("status read did not clear flags");

  a_period_flag: assert property (@(posedge clk) disable iff (!rstn)
    cmp_c |=> st_reg.flags[FLAG_PERIOD])
    else $error("period match flag missing");

  a_wave_hides_load: assert property (@(posedge clk) disable iff (!rstn)
    (rd_status && wave) |=> rdata[FLAG_OVERRUN] == 1'b0 && rdata[FLAG_LOAD_A] == 1'b0)
    else $error("capture flags visible in wave mode");

  a_capture_hides_cmp: assert property (@(posedge clk) disable iff (!rstn)
    (rd_status && !wave) |=> rdata[FLAG_MATCH_A] == 1'b0 && rdata[FLAG_MATCH_B] == 1'b0)
    else $error("compare flags visible in capture mode");

  a_enable_mask: assert property (@(posedge clk) disable iff (!rstn)
    (bus_req.wr && bus_req.addr == OFF_IRQ_EN) |=> (st_reg.mask & $past(bus_req.wdata[7:0])) == $past(bus_req.wdata[7:0]))
    else $error("enable port did not set mask");

  a_disable_mask: assert property (@(posedge clk) disable iff (!rstn)
    (bus_req.wr && bus_req.addr == OFF_IRQ_DIS) |=> (st_reg.mask & $past(bus_req.wdata[7:0])) == 8'h00)
    else $error("disable port did not clear mask");

  a_soft_trig_b: assert property (@(posedge clk) disable iff (!rstn)
    (sw_trig && wave && st_reg.mode[SW_EFF_B_LSB +: 2] == EFF_SET) |=> line_b_out)
    else $error("software trigger did not set line B");

  a_capture_readonly: assert property (@(posedge clk) disable iff (!rstn)
    (bus_req.wr && bus_req.addr == OFF_MATCH_A && !wave && !load_a) |=> st_reg.match_a == $past(st_reg.match_a))
    else $error("A match value written in capture mode");

  a_count_read: assert property (@(posedge clk) disable iff (!rstn)
    (bus_req.rd && bus_req.addr == OFF_COUNT) |=> rdata == 32'($past(st_reg.count)))
    else $error("count read wrong");

  a_irq_level: assert property (@(posedge clk) disable iff (!rstn)
    irq == |(st_reg.flags & st_reg.mask))
    else $error("interrupt does not follow flags and mask");

  a_soft_trig_a: assert property (@(posedge clk) disable iff (!rstn)
    (sw_trig && wave && st_reg.mode[SW_EFF_A_LSB +: 2] == EFF_CLEAR) |=> !line_a_out)
    else $error("software trigger did not clear line A");

  a_match_b_line: assert property (@(posedge clk) disable iff (!rstn)
    (cmp_b && wave && !cmp_c && !trigger && st_reg.mode[MATCH_B_EFF_B_LSB +: 2] == EFF_SET) |=> line_b_out)
    else $error("B match did not set line B");

  a_period_line_b: assert property (@(posedge clk) disable iff (!rstn)
    (cmp_c && wave && !trigger && st_reg.mode[PERIOD_EFF_B_LSB +: 2] == EFF_CLEAR) |=> !line_b_out)
    else $error("period match did not clear line B");

  a_ext_line_b: assert property (@(posedge clk) disable iff (!rstn)
    (ext_hit && wave && !sw_trig && st_reg.mode[EXT_EFF_B_LSB +: 2] == EFF_SET) |=> line_b_out)
    else $error("external event did not set line B");

  a_capture_lines_hold: assert property (@(posedge clk) disable iff (!rstn)
    !wave |=> $stable(line_a_out) && $stable(line_b_out))
    else $error("line driven level changed in capture mode");

  a_oe_follows_mode: assert property (@(posedge clk) disable iff (!rstn)
    line_a_oe_n == !wave && line_b_oe_n == !wave)
    else $error("output enable does not follow mode");

  a_match_b_readonly: assert property (@(posedge clk) disable iff (!rstn)
    (bus_req.wr && bus_req.addr == OFF_MATCH_B && !wave && !load_b) |=> st_reg.match_b == $past(st_reg.match_b))
    else $error("B match value written in capture mode");

  a_match_a_write: assert property (@(posedge clk) disable iff (!rstn)
    (bus_req.wr && bus_req.addr == OFF_MATCH_A && wave) |=> st_reg.match_a == $past(bus_req.wdata[CNT_W-1:0]))
    else $error("A match value not written in wave mode");

  a_period_write: assert property (@(posedge clk) disable iff (!rstn)
    (bus_req.wr && bus_req.addr == OFF_PERIOD) |=> st_reg.period == $past(bus_req.wdata[CNT_W-1:0]))
    else $error("period value not written");

  a_overrun_flag: assert property (@(posedge clk) disable iff (!rstn)
    (load_a && st_reg.a_unread) |=> st_reg.flags[FLAG_OVERRUN])
    else $error("double load did not set overrun flag");

  a_load_a_flag: assert property (@(posedge clk) disable iff (!rstn)
    load_a |=> st_reg.flags[FLAG_LOAD_A] && st_reg.match_a == $past(st_reg.count))
    else $error("A load did not capture count or set flag");

  a_load_b_flag: assert property (@(posedge clk) disable iff (!rstn)
    load_b |=> st_reg.flags[FLAG_LOAD_B] && st_reg.match_b == $past(st_reg.count))
    else $error("B load did not capture count or set flag");

  a_ext_flag: assert property (@(posedge clk) disable iff (!rstn)
    ext_hit |=> st_reg.flags[FLAG_EXT_TRIG])
    else $error("external trigger flag missing");

  a_match_a_flag: assert property (@(posedge clk) disable iff (!rstn)
    (cmp_a && wave) |=> st_reg.flags[FLAG_MATCH_A])
    else $error("A match flag missing in wave mode");

  a_status_clock: assert property (@(posedge clk) disable iff (!rstn)
    rd_status |=> rdata[STAT_CLOCK_ON] == $past(st_reg.clock_on))
    else $error("clock status bit wrong");

  a_mirror_b_wave: assert property (@(posedge clk) disable iff (!rstn)
    (rd_status && wave) |=> rdata[STAT_MIRROR_B] == $past(line_b_out))
    else $error("line B mirror differs from driven level");

  a_mask_read: assert property (@(posedge clk) disable iff (!rstn)
    (bus_req.rd && bus_req.addr == OFF_IRQ_MASK) |=> rdata == 32'($past(st_reg.mask)))
    else $error("interrupt mask read wrong");

endmodule : timer_channel_regs_status

// ---- tb/timer_lines_model.sv ----
module timer_lines_model (
  // Levels the far side puts on the lines when it owns them
  input wire logic a_lvl,
  input wire logic b_lvl,
  input wire logic ev_lvl,
  // Device drivers of the two lines
  input wire logic line_a_out,
  input wire logic line_a_oe_n,
  input wire logic line_b_out,
  input wire logic line_b_oe_n,
  // Resolved pin levels seen by the device
  output wire tc_chan_pkg::pins_in_s pins_in
);
  timeunit 1ns;
  timeprecision 1ps;
  import tc_chan_pkg::*;

  // Far side lets go of a line the device drives, so no contention
  assign pins_in.line_a_in = line_a_oe_n ? a_lvl : line_a_out;
  assign pins_in.line_b_in = line_b_oe_n ? b_lvl : line_b_out;
  assign pins_in.ext_event_in = ev_lvl;
endmodule : timer_lines_model

// ---- tb/tb_timer_channel_regs_status.sv ----
module tb_timer_channel_regs_status;
  timeunit 1ns;
  timeprecision 1ps;
  import tc_chan_pkg::*;

  localparam logic [31:0] WV = 32'h1 << MODE_WAVE;
  logic clk;
  logic rstn;
  bus_req_s bus_req;
  logic [31:0] rdata;
  pins_in_s pins_in;
  logic line_a_out;
  logic line_a_oe_n;
  logic line_b_out;
  logic line_b_oe_n;
  logic irq;
  logic a_lvl;
  logic b_lvl;
  logic ev_lvl;
  int n_errors;
  int compares;
  logic [31:0] d;
  logic [31:0] d2;
  logic la;
  logic lb;
  logic lv;
  int w;
  logic [5:0] offs [7] = '{OFF_COUNT, OFF_MATCH_A, OFF_MATCH_B, OFF_PERIOD, OFF_STATUS, OFF_IRQ_MASK, 6'h3c};
  logic [1:0] effs [4] = '{2'h1, 2'h2, 2'h3, 2'h0};
  logic [5:0] irq_a [5] = '{OFF_IRQ_EN, OFF_IRQ_EN, OFF_IRQ_DIS, OFF_IRQ_DIS, OFF_IRQ_DIS};
  logic [7:0] irq_w [5] = '{8'ha5, 8'h00, 8'h21, 8'h00, 8'hff};
  logic [7:0] irq_m [5] = '{8'ha5, 8'ha5, 8'h84, 8'h84, 8'h00};

  // Short counter so overflows and period matches come quickly
  timer_channel_regs_status #(.CNT_W(4)) timer_channel_regs_status_inst (.clk(clk), .rstn(rstn),
    .bus_req(bus_req), .rdata(rdata), .pins_in(pins_in), .line_a_out(line_a_out), .line_a_oe_n(line_a_oe_n),
    .line_b_out(line_b_out), .line_b_oe_n(line_b_oe_n), .irq(irq));

  timer_lines_model timer_lines_model_inst (.a_lvl(a_lvl), .b_lvl(b_lvl), .ev_lvl(ev_lvl),
    .line_a_out(line_a_out), .line_a_oe_n(line_a_oe_n), .line_b_out(line_b_out), .line_b_oe_n(line_b_oe_n),
    .pins_in(pins_in));

  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp)
    begin
      n_errors++;
      $display("ERROR %s expected %h seen %h", name, exp, got);
    end
  endtask : chk

  task automatic wr(input logic [5:0] a, input logic [31:0] v);
    @(posedge clk);
    bus_req <= '{addr: a, wdata: v, wr: 1'b1, rd: 1'b0};
    @(posedge clk);
    bus_req <= '0;
    #1;
  endtask : wr

  // Read data stand only in the cycle after the strobe
  task automatic rd(input logic [5:0] a, output logic [31:0] v);
    @(posedge clk);
    bus_req <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
    @(posedge clk);
    bus_req <= '0;
    #1;
    v = rdata;
  endtask : rd

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : cyc

  // Width of the next full segment of line B and its level
  task automatic seg(input bit sync, output logic v, output int n);
    logic s;
    s = line_b_out;
    n = 0;
    while (sync && line_b_out === s && n < 100)
    begin
      cyc(1);
      n++;
    end
    v = line_b_out;
    n = 0;
    while (line_b_out === v && n < 100)
    begin
      cyc(1);
      n++;
    end
  endtask : seg

  function automatic logic eff(input logic v, input logic [1:0] e);
    case (e)
      2'h1: eff = 1'b1;
      2'h2: eff = 1'b0;
      2'h3: eff = ~v;
      default: eff = v;
    endcase
  endfunction : eff

  task automatic end_of_test();
    $display("errors %0d compares %0d", n_errors, compares);
    if (n_errors == 0 && compares > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : end_of_test

  initial
  begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  initial
  begin
    #100us;
    n_errors++;
    end_of_test();
  end

  initial
  begin
    rstn = 1'b0;
    bus_req = '0;
    a_lvl = 1'b0;
    b_lvl = 1'b0;
    ev_lvl = 1'b0;
    la = 1'b0;
    lb = 1'b0;
    repeat (5) @(posedge clk);
    rstn <= 1'b1;
    foreach (offs[i])
    begin
      rd(offs[i], d);
      chk("reset read", 32'h0, d);
    end
    chk("oe_n capture", 32'h3, 32'({line_a_oe_n, line_b_oe_n}));
    $display("test reset done");
    wr(OFF_PERIOD, 32'h1234_abcd);
    rd(OFF_PERIOD, d);
    chk("period", 32'h0000_000d, d);
    wr(OFF_MATCH_A, 32'h55);
    rd(OFF_MATCH_A, d);
    chk("match a capture", 32'h0, d);
    wr(OFF_MATCH_B, 32'h55);
    rd(OFF_MATCH_B, d);
    chk("match b capture", 32'h0, d);
    foreach (irq_a[i])
    begin
      wr(irq_a[i], 32'(irq_w[i]));
      rd(OFF_IRQ_MASK, d);
      chk("irq mask", 32'(irq_m[i]), d);
    end
    $display("test registers done");
    wr(OFF_MODE, WV);
    chk("oe_n wave", 32'h0, 32'({line_a_oe_n, line_b_oe_n}));
    foreach (effs[i])
    begin
      wr(OFF_MODE, WV | (32'(effs[i]) << SW_EFF_A_LSB) | (32'(effs[(i + 1) % 4]) << SW_EFF_B_LSB));
      wr(OFF_CTRL, 32'h4);
      la = eff(la, effs[i]);
      lb = eff(lb, effs[(i + 1) % 4]);
      chk("line a sw", 32'(la), 32'(line_a_out));
      chk("line b sw", 32'(lb), 32'(line_b_out));
      rd(OFF_STATUS, d);
      chk("mirror clock", 32'({lb, la, 1'b1}), 32'(d[18:16]));
    end
    $display("test software trigger done");
    wr(OFF_MATCH_A, 32'h7);
    rd(OFF_MATCH_A, d);
    chk("match a wave", 32'h7, d);
    wr(OFF_MATCH_B, 32'h3);
    wr(OFF_PERIOD, 32'h9);
    wr(OFF_MODE, WV | (32'h1 << MATCH_B_EFF_B_LSB) | (32'h2 << PERIOD_EFF_B_LSB));
    for (int k = 0; k < 2; k++)
    begin
      seg(k == 0, lv, w);
      chk("line b level", 32'(k), 32'(lv));
      chk("line b width", (k != 0) ? 32'd6 : 32'd10, 32'(w));
    end
    rd(OFF_STATUS, d);
    chk("wave flags", 32'h1d, 32'(d[6:0]));
    $display("test compare done");
    wr(OFF_MODE, WV | (32'h1 << EXT_EDGE_LSB) | (32'h1 << EXT_EFF_B_LSB) | (32'h2 << SW_EFF_B_LSB));
    wr(OFF_CTRL, 32'h4);
    wr(OFF_CTRL, 32'h2);
    chk("line b cleared", 32'h0, 32'(line_b_out));
    rd(OFF_STATUS, d);
    @(posedge clk);
    ev_lvl <= 1'b1;
    for (int k = 0; k < 10 && line_b_out !== 1'b1; k++)
      cyc(1);
    chk("line b ext", 32'h1, 32'(line_b_out));
    wr(OFF_CTRL, 32'h2);
    rd(OFF_STATUS, d);
    chk("ext flag", 32'h1, 32'(d[FLAG_EXT_TRIG]));
    rd(OFF_STATUS, d);
    chk("flags cleared", 32'h0, 32'({d[16], d[7:0]}));
    rd(OFF_COUNT, d);
    rd(OFF_COUNT, d2);
    chk("count stopped", d, d2);
    chk("count upper", 32'h0, 32'(d[31:4]));
    $display("test external event done");
    wr(OFF_IRQ_EN, 32'h1 << FLAG_OVERFLOW);
    chk("irq idle", 32'h0, 32'(irq));
    wr(OFF_CTRL, 32'h1);
    cyc(20);
    chk("irq overflow", 32'h1, 32'(irq));
    wr(OFF_CTRL, 32'h2);
    rd(OFF_STATUS, d);
    cyc(2);
    chk("irq cleared", 32'h0, 32'(irq));
    $display("test interrupt done");
    wr(OFF_MODE, (32'h1 << LOAD_A_EDGE_LSB) | (32'h2 << LOAD_B_EDGE_LSB));
    chk("oe_n capture", 32'h3, 32'({line_a_oe_n, line_b_oe_n}));
    wr(OFF_CTRL, 32'h1);
    rd(OFF_STATUS, d);
    repeat (3)
    begin
      @(posedge clk);
      a_lvl <= ~a_lvl;
      cyc(7);
    end
    rd(OFF_STATUS, d);
    chk("capture flags", 32'h73, 32'(d[6:0]));
    chk("capture mirror", 32'h1, 32'(d[18:17]));
    wr(OFF_CTRL, 32'h2);
    $display("test capture done");
    end_of_test();
  end
endmodule : tb_timer_channel_regs_status
